//--- irda_dma_device.sv
// DMA control of the infrared unit: configuration, run control and request pacing.
// Assumes the master obeys the link handshake and the FIFOs sit outside this block.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps

// Behaviour
// - Reserved bits read zero, written as zero.
// - Access mode bit written zero, reads zero.
// - Direction zero: memory to transmit; one: receive.
// - Demand codes give one to seven; seven free.
// - Configuration untouched while any DMA runs.
// - Full medium rate uses pulse width 01001.
// - Half medium rate uses pulse width 10100.
// - Medium-rate control untouched during traffic.
// - Writing enable one starts the transfer.
// - Writing enable zero never stops a transfer.
// - Busy sets with enable, zero when idle.
// - Busy clears on frame status or tx end; here tx end clears it in transmit direction only.
module irda_dma_device
   import irda_dma_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   irda_dma_if.device bus,
   input wire logic [LEVEL_W-1:0] tx_space,
   output logic tx_push,
   output logic [15:0] tx_data,
   input wire logic [LEVEL_W-1:0] rx_count,
   input wire logic [15:0] rx_data,
   output logic rx_pop,
   input wire logic frame_status_set,
   input wire logic tx_frame_done,
   output logic transfer_direction,
   output logic [2:0] burst_demand_size,
   output logic busy
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic enable;
   logic cfg_hit;
   logic run_hit;
   logic cfg_write;
   logic run_write;
   logic busy_set;
   logic busy_clear;
   logic [15:0] cfg_view;
   logic [15:0] run_view;
   logic [15:0] next_rdata;
   logic [LEVEL_W-1:0] pace_level;
   logic unit_taken;
   logic tx_taken;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   always_comb
   begin
      cfg_hit = 1'b0;
      run_hit = 1'b0;
      if (bus.reg_addr == DMA_TRANSFER_CONFIG_ADDR)
         cfg_hit = 1'b1;
      else if (bus.reg_addr == DMA_RUN_CONTROL_ADDR)
         run_hit = 1'b1;
   end

   assign cfg_write = bus.reg_wr && cfg_hit;
   assign run_write = bus.reg_wr && run_hit;

   // ---------------------------------------------------------------
   // Transfer configuration
   // ---------------------------------------------------------------
   // Only the direction and demand bits are stored; the access mode bit and
   // the reserved bits have no flip-flop behind them, so they cannot stick.
   // Writes are taken even while busy: keeping
   // the configuration still in a transfer is the
   // master's duty, and it drops such writes.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         transfer_direction <= CFG_RESET[CFG_DIRECTION_BIT];
         burst_demand_size <= CFG_RESET[CFG_DEMAND_MSB:CFG_DEMAND_LSB];
      end
      else if (ce && cfg_write)
      begin
         transfer_direction <= bus.reg_wdata[CFG_DIRECTION_BIT];
         burst_demand_size <= bus.reg_wdata[CFG_DEMAND_MSB:CFG_DEMAND_LSB];
      end
   end

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         enable <= RUN_RESET[RUN_ENABLE_BIT];
      else if (ce && run_write)
         enable <= bus.reg_wdata[RUN_ENABLE_BIT];
   end

   // Writing one is the trigger; writing zero only clears the enable bit and
   // leaves busy alone, so a running transfer goes on to its own end.
   assign busy_set = run_write && bus.reg_wdata[RUN_ENABLE_BIT];
   // The end of transmit data only counts for the transmit direction.
   assign busy_clear = frame_status_set || (tx_frame_done && !transfer_direction);

   // A start in the same cycle as a completion wins, so no trigger is lost.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         busy <= RUN_RESET[RUN_BUSY_BIT];
      else if (ce)
      begin
         if (busy_set)
            busy <= 1'b1;
         else if (busy_clear)
            busy <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register read back
   // ---------------------------------------------------------------
   always_comb
   begin
      cfg_view = 16'h0000;
      cfg_view[CFG_ACCESS_MODE_BIT] = 1'b0;
      cfg_view[CFG_DIRECTION_BIT] = transfer_direction;
      cfg_view[CFG_DEMAND_MSB:CFG_DEMAND_LSB] = burst_demand_size;
      run_view = 16'h0000;
      run_view[RUN_BUSY_BIT] = busy;
      run_view[RUN_ENABLE_BIT] = enable;
   end

   always_comb
   begin
      next_rdata = 16'h0000;
      if (cfg_hit)
         next_rdata = cfg_view;
      else if (run_hit)
         next_rdata = run_view;
   end

   // Read data stand in the cycle after the strobe and then return to zero.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         bus.reg_rdata <= WORD_RESET;
      else if (ce)
      begin
         if (bus.reg_rd)
            bus.reg_rdata <= next_rdata;
         else
            bus.reg_rdata <= WORD_RESET;
      end
   end

   // ---------------------------------------------------------------
   // Request pacing
   // ---------------------------------------------------------------
   // The level must drop the cycle after each unit.
   assign pace_level = transfer_direction ? rx_count : tx_space;

   burst_pacer burst_pacer_i (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .busy(busy),
      .demand(burst_demand_size),
      .level(pace_level),
      .ack(unit_taken),
      .req(bus.dma_req)
   );

   assign unit_taken = bus.dma_ack && bus.dma_req;
   assign tx_taken = unit_taken && !transfer_direction;

   // ---------------------------------------------------------------
   // Data ports
   // ---------------------------------------------------------------
   // Transmit units are registered once, which adds a cycle of latency but
   // keeps the framing side away from the master's combinational paths.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tx_push <= 1'b0;
         tx_data <= WORD_RESET;
      end
      else if (ce)
      begin
         tx_push <= tx_taken;
         if (tx_taken)
            tx_data <= bus.dma_wdata;
      end
   end

   // The receive head is already a FIFO register; it is passed straight on.
   assign rx_pop = unit_taken && transfer_direction && ce;
   assign bus.dma_rdata = rx_data;
   assign bus.dma_dir = transfer_direction;
   assign bus.dma_busy = busy;

endmodule

//--- irda_dma_pkg.sv
// Constants, field layouts and types shared by both ends of the infrared DMA link.
// Assumes every user of it runs on one clock and imports it whole.
package irda_dma_pkg;

   // ---------------------------------------------------------------
   // Device register addresses
   // ---------------------------------------------------------------
   localparam logic [31:0] MEDIUM_RATE_CONTROL_ADDR = 32'h0c000060;
   localparam logic [31:0] DMA_TRANSFER_CONFIG_ADDR = 32'h0c000062;
   localparam logic [31:0] DMA_RUN_CONTROL_ADDR = 32'h0c000064;

   // ---------------------------------------------------------------
   // Field positions and values after reset
   // ---------------------------------------------------------------
   localparam int CFG_ACCESS_MODE_BIT = 7;
   localparam int CFG_DIRECTION_BIT = 6;
   localparam int CFG_DEMAND_MSB = 2;
   localparam int CFG_DEMAND_LSB = 0;
   localparam int RUN_BUSY_BIT = 1;
   localparam int RUN_ENABLE_BIT = 0;
   localparam int RATE_STA_LEN_LSB = 5;
   localparam int RATE_PULSE_LSB = 0;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] RUN_RESET = 16'h0000;
   localparam logic [2:0] DEMAND_FREE = 3'h7;
   localparam logic [2:0] RATE_STA_LEN_KEEP = 3'h2;
   localparam logic [4:0] PULSE_WIDTH_FULL = 5'h09;
   localparam logic [4:0] PULSE_WIDTH_HALF = 5'h14;

   // ---------------------------------------------------------------
   // Master's own register offsets and memory
   // ---------------------------------------------------------------
   localparam logic [7:0] HOST_CFG_OFS = 8'h00;
   localparam logic [7:0] HOST_RUN_OFS = 8'h04;
   localparam logic [7:0] HOST_RATE_OFS = 8'h08;
   localparam logic [7:0] HOST_PTR_OFS = 8'h0c;
   localparam logic [7:0] HOST_PEEK_OFS = 8'h10;
   localparam logic [1:0] HOST_MEM_TAG = 2'h1;
   localparam int MEM_DEPTH = 16;
   localparam int MEM_AW = 4;
   localparam int LEVEL_W = 4;
   localparam logic [MEM_AW-1:0] PTR_RESET = 4'h0;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      PACE_IDLE = 1'b0,
      PACE_BURST = 1'b1
   } pace_state_t;

endpackage

//--- irda_dma_if.sv
// Link between the infrared unit's DMA control and the system DMA master.
// Assumes both ends share one clock; the master drives register accesses and acks.
`timescale 1ns/100ps
interface irda_dma_if;
   logic [31:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic dma_req;
   logic dma_ack;
   logic dma_dir;
   logic dma_busy;
   logic [15:0] dma_wdata;
   logic [15:0] dma_rdata;

   modport device (
      input reg_addr,
      input reg_wdata,
      input reg_wr,
      input reg_rd,
      output reg_rdata,
      output dma_req,
      input dma_ack,
      output dma_dir,
      output dma_busy,
      input dma_wdata,
      output dma_rdata
   );

   modport master (
      output reg_addr,
      output reg_wdata,
      output reg_wr,
      output reg_rd,
      input reg_rdata,
      input dma_req,
      output dma_ack,
      input dma_dir,
      input dma_busy,
      output dma_wdata,
      input dma_rdata
   );
endinterface

//--- burst_pacer.sv
// Paces transfer requests in bursts of the programmed demand size.
// Assumes the level input counts units ready, updated the cycle after each ack.
`timescale 1ns/100ps
module burst_pacer
   import irda_dma_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic busy,
   input wire logic [2:0] demand,
   input wire logic [LEVEL_W-1:0] level,
   input wire logic ack,
   output logic req
);

   pace_state_t state;
   logic [LEVEL_W-1:0] remaining;
   logic [LEVEL_W-1:0] size;
   logic free_size;
   logic enough;

   // ---------------------------------------------------------------
   // Demand decode
   // ---------------------------------------------------------------
   assign free_size = (demand == DEMAND_FREE);
   assign size = {1'b0, demand} + 4'h1;
   assign enough = free_size ? (level != 4'h0) : (level >= size);

   // ---------------------------------------------------------------
   // Burst sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= PACE_IDLE;
         remaining <= 4'h0;
      end
      else if (ce)
      begin
         case (state)
            PACE_IDLE:
            begin
               if (busy && enough)
               begin
                  state <= PACE_BURST;
                  remaining <= size;
               end
            end
            PACE_BURST:
            begin
               if (!busy)
                  state <= PACE_IDLE;
               else if (ack)
               begin
                  remaining <= remaining - 4'h1;
                  // A free burst ends when the unit runs out, not on a count.
                  if (free_size ? (level == 4'h1) : (remaining == 4'h1))
                     state <= PACE_IDLE;
               end
            end
            default:
               state <= PACE_IDLE;
         endcase
      end
   end

   assign req = (state == PACE_BURST) && busy;

endmodule

//--- irda_dma_master.sv
// System DMA master: moves units between a local memory and the infrared unit.
// Assumes software on the plain port, one device on the link, one clock.
`timescale 1ns/100ps
module irda_dma_master
   import irda_dma_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   irda_dma_if.master bus,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata
);

   logic [15:0] mem [MEM_DEPTH];
   logic cfg_dir;
   logic [2:0] cfg_demand;
   logic run_enable;
   logic rate_half;
   logic [MEM_AW-1:0] ptr;
   logic [15:0] peek_value;
   logic peek_wait;
   logic active;
   logic run_pending;
   logic mem_hit;
   logic [MEM_AW-1:0] mem_index;
   logic [15:0] next_rdata;

   assign run_pending = bus.reg_wr && bus.reg_addr == DMA_RUN_CONTROL_ADDR &&
                        bus.reg_wdata[RUN_ENABLE_BIT];
   assign active = bus.dma_busy || bus.dma_req || run_pending;
   assign mem_hit = (addr[7:6] == HOST_MEM_TAG);
   assign mem_index = addr[MEM_AW+1:2];
   assign bus.dma_ack = bus.dma_req && ce;
   assign bus.dma_wdata = mem[ptr];

   // ---------------------------------------------------------------
   // Own registers and forwarding to the device
   // ---------------------------------------------------------------
   // Writes that would disturb a running transfer are dropped silently;
   // software sees this only by reading the shadow back.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_dir <= 1'b0;
         cfg_demand <= 3'h0;
         run_enable <= 1'b0;
         rate_half <= 1'b0;
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         bus.reg_addr <= 32'h00000000;
         bus.reg_wdata <= WORD_RESET;
      end
      else if (ce)
      begin
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         if (wr && addr == HOST_CFG_OFS && !active)
         begin
            cfg_dir <= wdata[CFG_DIRECTION_BIT];
            cfg_demand <= wdata[CFG_DEMAND_MSB:CFG_DEMAND_LSB];
            bus.reg_wr <= 1'b1;
            bus.reg_addr <= DMA_TRANSFER_CONFIG_ADDR;
            bus.reg_wdata <= {8'h00, 1'b0, wdata[CFG_DIRECTION_BIT], 3'h0,
                              wdata[CFG_DEMAND_MSB:CFG_DEMAND_LSB]};
         end
         else if (wr && addr == HOST_RUN_OFS)
         begin
            run_enable <= wdata[RUN_ENABLE_BIT];
            bus.reg_wr <= 1'b1;
            bus.reg_addr <= DMA_RUN_CONTROL_ADDR;
            bus.reg_wdata <= {15'h0000, wdata[RUN_ENABLE_BIT]};
         end
         else if (wr && addr == HOST_RATE_OFS && !active)
         begin
            rate_half <= wdata[0];
            bus.reg_wr <= 1'b1;
            bus.reg_addr <= MEDIUM_RATE_CONTROL_ADDR;
            bus.reg_wdata <= {8'h00, RATE_STA_LEN_KEEP,
                              wdata[0] ? PULSE_WIDTH_HALF : PULSE_WIDTH_FULL};
         end
         else if (wr && addr == HOST_PEEK_OFS)
         begin
            bus.reg_rd <= 1'b1;
            bus.reg_addr <= wdata[0] ? DMA_RUN_CONTROL_ADDR : DMA_TRANSFER_CONFIG_ADDR;
         end
      end
   end

   // The device answers one cycle after its read strobe.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         peek_wait <= 1'b0;
         peek_value <= WORD_RESET;
      end
      else if (ce)
      begin
         peek_wait <= bus.reg_rd;
         if (peek_wait)
            peek_value <= bus.reg_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Memory and transfer pointer
   // ---------------------------------------------------------------
   // A unit moved by the link overrides a software write to the same word.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ptr <= PTR_RESET;
         for (int i = 0; i < MEM_DEPTH; i++)
            mem[i] <= WORD_RESET;
      end
      else if (ce)
      begin
         if (wr && mem_hit)
            mem[mem_index] <= wdata;
         if (bus.dma_ack && bus.dma_dir)
            mem[ptr] <= bus.dma_rdata;
         if (wr && addr == HOST_PTR_OFS)
            ptr <= wdata[MEM_AW-1:0];
         else if (bus.dma_ack)
            ptr <= ptr + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Read back
   // ---------------------------------------------------------------
   always_comb
   begin
      next_rdata = 16'h0000;
      if (mem_hit)
         next_rdata = mem[mem_index];
      else if (addr == HOST_CFG_OFS)
         next_rdata = {9'h000, cfg_dir, 3'h0, cfg_demand};
      else if (addr == HOST_RUN_OFS)
         next_rdata = {14'h0000, bus.dma_busy, run_enable};
      else if (addr == HOST_RATE_OFS)
         next_rdata = {15'h0000, rate_half};
      else if (addr == HOST_PTR_OFS)
         next_rdata = {12'h000, ptr};
      else if (addr == HOST_PEEK_OFS)
         next_rdata = peek_value;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata <= WORD_RESET;
      else if (ce)
         rdata <= rd ? next_rdata : WORD_RESET;
   end

endmodule

//--- irda_dma_control_checker.sv
// Concurrent checks on the link between the infrared DMA control and the DMA master.
// Assumes one clock, ce held high, and the signals of one irda_dma_if instance.
`timescale 1ns/100ps
module irda_dma_control_checker
   import irda_dma_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [31:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic dma_req,
   input wire logic dma_ack,
   input wire logic dma_dir,
   input wire logic dma_busy
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic cfg_wr;
   logic run_wr;
   logic rate_wr;
   logic [2:0] cfg_demand;
   logic [3:0] ack_count;
   logic cfg_rd;
   logic enable_wr;
   logic quiet;
   logic rate_ok;
   logic [3:0] burst_size;
   assign cfg_wr = reg_wr && reg_addr == DMA_TRANSFER_CONFIG_ADDR;
   assign cfg_rd = reg_rd && reg_addr == DMA_TRANSFER_CONFIG_ADDR;
   assign enable_wr = run_wr && reg_wdata[0];
   assign quiet = !dma_busy && !dma_req;
   assign rate_ok = reg_wdata == 16'h0049 || reg_wdata == 16'h0054;
   assign burst_size = {1'b0, cfg_demand} + 4'h1;
   assign run_wr = reg_wr && reg_addr == DMA_RUN_CONTROL_ADDR;
   assign rate_wr = reg_wr && reg_addr == MEDIUM_RATE_CONTROL_ADDR;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cfg_demand <= 3'h0;
      else if (cfg_wr)
         cfg_demand <= reg_wdata[2:0];
   end

   // The count restarts whenever the request is low, so it holds the acks of one burst.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ack_count <= 4'h0;
      else if (!dma_req)
         ack_count <= 4'h0;
      else if (dma_ack)
         ack_count <= ack_count + 4'h1;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence enable_write;
      enable_wr;
   endsequence

   sequence burst_end;
      dma_req ##1 (!dma_req && dma_busy && cfg_demand != DEMAND_FREE);
   endsequence

   sequence last_fixed_unit;
      dma_ack && dma_busy && cfg_demand != DEMAND_FREE && ack_count + 4'h1 == burst_size;
   endsequence

   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data present without a read");
   a_cfg_read_clean: assert property ($past(cfg_rd) |-> (reg_rdata & 16'hffb8) == 16'h0000)
      else $error("config read shows reserved or access mode bits");
   a_cfg_write_clean: assert property (cfg_wr |-> (reg_wdata & 16'hffb8) == 16'h0000)
      else $error("config written with reserved bits set");
   a_dir_follows_cfg: assert property (cfg_wr |=> dma_dir == $past(reg_wdata[6]))
      else $error("direction does not follow the config write");
   a_burst_exact_length: assert property (burst_end |-> ack_count == burst_size)
      else $error("burst length differs from demand size");
   a_config_quiet_busy: assert property (cfg_wr || rate_wr |-> $past(quiet))
      else $error("config or rate written during a transfer");
   a_rate_pulse_value: assert property (rate_wr |-> rate_ok)
      else $error("medium rate pulse width not a permitted value");
   a_enable_sets_busy: assert property (enable_write |=> dma_busy)
      else $error("busy not set after enable");
   a_disable_keeps_busy: assert property (run_wr && !enable_wr && dma_busy |=> dma_busy)
      else $error("clearing enable stopped the transfer");
   a_busy_has_cause: assert property ($rose(dma_busy) |-> $past(enable_wr))
      else $error("busy rose without an enable write");
   a_req_needs_busy: assert property (dma_req |-> dma_busy)
      else $error("request while not busy");
   a_burst_gap_idle: assert property (last_fixed_unit |=> !dma_req)
      else $error("request held past the last unit of a burst");
endmodule

//--- irda_dma_control_test.sv
// Testbench joining the device end and the master end of the infrared DMA link.
// Assumes the checker and design files are compiled first; drives host port and FIFO side.
`timescale 1ns/100ps
module irda_dma_control_test
   import irda_dma_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic reset_n, ce, wr, rd, frame_status_set, tx_frame_done;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, rx_data, tx_data, seen;
   logic [LEVEL_W-1:0] tx_space, rx_count;
   logic tx_push, rx_pop, transfer_direction, busy;
   logic [2:0] burst_demand_size;
   logic [15:0] tx_q[$];
   int miscompares = 0;
   int samples_checked = 0;
   int pop_n = 0;

   always #5 clk = ~clk;

   irda_dma_if irda_dma_if_i ();
   irda_dma_device irda_dma_device_i (.clk(clk), .reset_n(reset_n), .ce(ce),
      .bus(irda_dma_if_i), .tx_space(tx_space), .tx_push(tx_push), .tx_data(tx_data),
      .rx_count(rx_count), .rx_data(rx_data), .rx_pop(rx_pop),
      .frame_status_set(frame_status_set), .tx_frame_done(tx_frame_done),
      .transfer_direction(transfer_direction), .burst_demand_size(burst_demand_size),
      .busy(busy));
   irda_dma_master irda_dma_master_i (.clk(clk), .reset_n(reset_n), .ce(ce),
      .bus(irda_dma_if_i), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   irda_dma_control_checker irda_dma_control_checker_i (.clk(clk), .reset_n(reset_n),
      .reg_addr(irda_dma_if_i.reg_addr), .reg_wdata(irda_dma_if_i.reg_wdata),
      .reg_wr(irda_dma_if_i.reg_wr), .reg_rd(irda_dma_if_i.reg_rd),
      .reg_rdata(irda_dma_if_i.reg_rdata), .dma_req(irda_dma_if_i.dma_req),
      .dma_ack(irda_dma_if_i.dma_ack), .dma_dir(irda_dma_if_i.dma_dir),
      .dma_busy(irda_dma_if_i.dma_busy));

   always @(posedge clk)
   begin
      if (tx_push === 1'b1)
         tx_q.push_back(tx_data);
      if (rx_pop === 1'b1)
         pop_n++;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   // Each access leaves one idle cycle so a strobe is never lowered and raised in one step.
   task automatic host_wr(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_check(input string what, input logic [7:0] a, input logic [15:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      check(what, rdata, exp);
   endtask

   task automatic peek(input string what, input logic sel, input logic [15:0] exp);
      host_wr(HOST_PEEK_OFS, {15'h0000, sel});
      @(posedge clk);
      rd_check(what, HOST_PEEK_OFS, exp);
   endtask

   task automatic pulse(input logic frame);
      if (frame)
         frame_status_set <= 1'b1;
      else
         tx_frame_done <= 1'b1;
      @(posedge clk);
      frame_status_set <= 1'b0;
      tx_frame_done <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic wait_req();
      int k;
      k = 0;
      while (irda_dma_if_i.dma_req !== 1'b1 && k < 40)
      begin
         @(posedge clk);
         k++;
      end
      check("request", 16'(irda_dma_if_i.dma_req), 16'h0001);
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial
   begin
      reset_n = 1'b0;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      tx_space = 4'h0;
      rx_count = 4'h0;
      rx_data = 16'h0000;
      frame_status_set = 1'b0;
      tx_frame_done = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      peek("config after reset", 1'b0, CFG_RESET);
      peek("run after reset", 1'b1, RUN_RESET);
      rd_check("unmapped read", 8'h20, 16'h0000);
      host_wr(HOST_CFG_OFS, 16'hffff);
      @(posedge clk);
      check("direction", 16'(transfer_direction), 16'h0001);
      check("free demand", 16'(burst_demand_size), 16'(DEMAND_FREE));
      peek("config readback", 1'b0, 16'h0047);
      for (int d = 0; d < 7; d++)
      begin
         host_wr(HOST_CFG_OFS, 16'(d));
         @(posedge clk);
         check("demand code", 16'(burst_demand_size), 16'(d));
      end
      ce <= 1'b0;
      host_wr(HOST_CFG_OFS, 16'h0042);
      ce <= 1'b1;
      check("demand frozen", 16'(burst_demand_size), 16'h0006);
      host_wr(HOST_CFG_OFS, 16'h0001);
      for (int i = 0; i < 4; i++)
         host_wr(8'h40 + 8'(4 * i), 16'h1110 + 16'(i));
      host_wr(HOST_PTR_OFS, 16'h0000);
      host_wr(HOST_RATE_OFS, 16'h0001);
      host_wr(HOST_RATE_OFS, 16'h0000);
      host_wr(HOST_RUN_OFS, 16'h0001);
      @(posedge clk);
      check("busy on enable", 16'(busy), 16'h0001);
      repeat (4)
      begin
         @(posedge clk);
         check("idle without space", 16'(irda_dma_if_i.dma_req), 16'h0000);
      end
      host_wr(HOST_CFG_OFS, 16'h0046);
      @(posedge clk);
      check("config held while busy", 16'(burst_demand_size), 16'h0001);
      host_wr(HOST_RUN_OFS, 16'h0000);
      @(posedge clk);
      check("busy after disable", 16'(busy), 16'h0001);
      peek("run while busy", 1'b1, 16'h0002);
      tx_space <= 4'h2;
      wait_req();
      tx_space <= 4'h0;
      repeat (6) @(posedge clk);
      check("units pushed", 16'(tx_q.size()), 16'h0002);
      check("first unit", tx_q[0], 16'h1110);
      check("second unit", tx_q[1], 16'h1111);
      pulse(1'b0);
      check("busy after transmit end", 16'(busy), 16'h0000);
      host_wr(HOST_CFG_OFS, 16'h0047);
      rx_data <= 16'h5a3c;
      host_wr(HOST_RUN_OFS, 16'h0001);
      pulse(1'b0);
      check("busy kept on receive", 16'(busy), 16'h0001);
      rx_count <= 4'h1;
      wait_req();
      rx_count <= 4'h0;
      repeat (4) @(posedge clk);
      check("units popped", 16'(pop_n), 16'h0001);
      rd_check("received unit", 8'h48, 16'h5a3c);
      pulse(1'b1);
      check("busy after frame status", 16'(busy), 16'h0000);
      rd_check("run idle", HOST_RUN_OFS, 16'h0001);
      summarize();
   end
endmodule
